// ---- rtl/rirq_pkg.sv ----
//****************************************************************
// reader interrupt request unit: shared constants and types
//****************************************************************
// holds register offsets, field positions, reset values, carriers.
// assumes a 32-bit apb master and a single 50 mhz clock domain.
//
// Contract
// (R1) invert bit set: interrupt pin shows inverse of global request status.
// (R2) invert bit clear: interrupt pin follows global request status.
// (R3) reset defaults with open-drain: pin floats while nothing enabled is pending.
// (R4) common enable bits 6..0 pass matching requests; clear bits block them.
// (R5) secondary enable bit 7 selects push-pull when 1, open-drain when 0.
// (R6) secondary enable bit 4 gates aux activity, bit 2 crc; rest reserved.
// (R7) reset: common enable 80h, secondary enable 00h, common request 14h.
// (R8) common request write: bit 7 set marks set, clear marks clear.
// (R9) software clears latched requests; hardware never auto-clears them.
// (R10) transmit request bit 6 set when last transmitted bit has left.
// (R11) receive request bit 5 set at end of valid incoming stream.
// (R12) ignore-empty mode: receive request set only with bytes in fifo.
// (R13) idle request bit 4 set when running command ends by itself.
// (R14) unknown command: command field returns to idle, idle request set.
// (R15) host writing idle command does not set idle request.
// (R16) high alert request bit 3 latched on rising live high alert.
// (R17) low alert request bit 2 latched on rising live low alert.
// (R18) error request bit 1 set when any error status bit becomes set.
// (R19) timer request bit 0 set when timer counts down to zero.
// (R20) secondary request write uses bit 7 marker the same way.
// (R21) aux activity request bit 4 set on either edge of aux input.
// (R22) crc request bit 2 set when crc command done processing.
// (R23) global status is OR of enabled requests, one cycle behind.

package rirq_pkg;

    //****************************************************************
    // register map (byte addresses)
    //****************************************************************
    localparam logic [7:0] RIRQ_COMMAND_OFS     = 8'h04;
    localparam logic [7:0] RIRQ_COM_IEN_OFS     = 8'h08;
    localparam logic [7:0] RIRQ_DIV_IEN_OFS     = 8'h0c;
    localparam logic [7:0] RIRQ_COM_IRQ_OFS     = 8'h10;
    localparam logic [7:0] RIRQ_DIV_IRQ_OFS     = 8'h14;
    localparam logic [7:0] RIRQ_STATUS_OFS      = 8'h18;
    localparam logic [7:0] RIRQ_MODE_OFS        = 8'h1c;

    //****************************************************************
    // reset values and masks
    //****************************************************************
    localparam logic [7:0] RIRQ_COM_IEN_RST     = 8'h80;
    localparam logic [7:0] RIRQ_DIV_IEN_RST     = 8'h00;
    localparam logic [7:0] RIRQ_COM_IRQ_RST     = 8'h14;
    localparam logic [7:0] RIRQ_DIV_IRQ_RST     = 8'h00;
    localparam logic [7:0] RIRQ_MODE_RST        = 8'h00;
    localparam logic [7:0] RIRQ_DIV_IEN_MASK    = 8'h94;
    localparam logic [7:0] RIRQ_DIV_IRQ_MASK    = 8'h14;
    localparam logic [3:0] RIRQ_CMD_IDLE        = 4'h0;
    localparam logic [3:0] RIRQ_CMD_CALC_CRC    = 4'h3;
    localparam logic [15:0] RIRQ_CMD_VALID      = 16'hf3bb;

    //****************************************************************
    // field positions
    //****************************************************************
    localparam int RIRQ_MARKER_BIT    = 7;
    localparam int RIRQ_INVERT_BIT    = 7;
    localparam int RIRQ_PUSH_PULL_BIT = 7;
    localparam int RIRQ_TX_BIT        = 6;
    localparam int RIRQ_RX_BIT        = 5;
    localparam int RIRQ_IDLE_BIT      = 4;
    localparam int RIRQ_HIGH_BIT      = 3;
    localparam int RIRQ_LOW_BIT       = 2;
    localparam int RIRQ_ERR_BIT       = 1;
    localparam int RIRQ_TIMER_BIT     = 0;
    localparam int RIRQ_AUX_BIT       = 4;
    localparam int RIRQ_CRC_BIT       = 2;
    localparam int RIRQ_RX_IGNORE_BIT = 3;

    //****************************************************************
    // carriers
    //****************************************************************
    typedef struct packed {
        logic       tx_last_bit_sent;   // transmitter finished
        logic       rx_stream_end;      // receiver saw valid end
        logic       fifo_has_bytes;     // fifo not empty
        logic       fifo_high_live;     // live high alert
        logic       fifo_low_live;      // live low alert
        logic [7:0] error_status;       // error status bits
        logic       timer_zero;         // timer reached zero
        logic       cmd_done;           // running command finished
        logic       crc_data_done;      // crc input consumed
    } rirq_events_t;

    typedef struct packed {
        logic [7:0] paddr;
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [31:0] pwdata;
    } rirq_apb_req_t;

endpackage

// ---- rtl/rirq_unit.sv ----
//****************************************************************
// reader interrupt request unit
//****************************************************************
// holds request latches, enables, command field and pin drive.
// assumes synchronous event pulses from sources on the same clock,
// and an aux pin input from outside that is synchronised here.

module rirq_unit
    import rirq_pkg::*;
(
    input  wire logic                   CLK_SYS,     // 50 mhz clock
    input  wire logic                   RESETN,      // sync reset, low
    input  wire rirq_pkg::rirq_apb_req_t APB_REQ,    // apb request
    output logic [31:0]                 PRDATA,      // apb read data
    output logic                        PREADY,      // apb ready
    output logic                        PSLVERR,     // apb error
    input  wire rirq_pkg::rirq_events_t EVENTS,      // source events
    input  wire logic                   AUX_SERIAL_INPUT, // aux pin
    output logic [3:0]                  COMMAND,     // active command
    output logic                        IRQ_STATUS,  // global request
    output logic                        IRQ_O,       // pin out level
    output logic                        IRQ_OE_N     // pin drive, low on
);

    //****************************************************************
    // state
    //****************************************************************
    logic [7:0] com_ien_q, com_ien_d;
    logic [7:0] div_ien_q, div_ien_d;
    logic [7:0] com_irq_q, com_irq_d;
    logic [7:0] div_irq_q, div_irq_d;
    logic [7:0] mode_q,    mode_d;
    logic [3:0] cmd_q,     cmd_d;
    logic       irq_q;
    logic       irq_out_q;
    logic       irq_oe_n_q;
    logic       high_prev_q;
    logic       low_prev_q;
    logic [7:0] err_prev_q;
    logic       aux_s1_q, aux_s2_q, aux_s3_q;
    logic [7:0] rd_q;

    //****************************************************************
    // bus decode
    //****************************************************************
    wire logic        wr_en   = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
    wire logic        setup_en = APB_REQ.psel & ~APB_REQ.penable; // setup cycle
    wire logic [7:0]  wdat    = APB_REQ.pwdata[7:0];
    wire logic        hit_cmd = APB_REQ.paddr == RIRQ_COMMAND_OFS;
    wire logic        hit_cie = APB_REQ.paddr == RIRQ_COM_IEN_OFS;
    wire logic        hit_die = APB_REQ.paddr == RIRQ_DIV_IEN_OFS;
    wire logic        hit_cir = APB_REQ.paddr == RIRQ_COM_IRQ_OFS;
    wire logic        hit_dir = APB_REQ.paddr == RIRQ_DIV_IRQ_OFS;
    wire logic        hit_sta = APB_REQ.paddr == RIRQ_STATUS_OFS;
    wire logic        hit_mod = APB_REQ.paddr == RIRQ_MODE_OFS;
    wire logic        hit_any = hit_cmd | hit_cie | hit_die | hit_cir
                                | hit_dir | hit_sta | hit_mod;

    // marker-bit write: set or clear the bits written as one
    function automatic logic [7:0] marker_write(input logic [7:0] cur,
                                                input logic [7:0] wd,
                                                input logic [7:0] msk);
        logic [7:0] sel;
        sel = wd & msk;
        if (wd[RIRQ_MARKER_BIT]) begin
            marker_write = cur | sel;
        end else begin
            marker_write = cur & ~sel;
        end
    endfunction

    //****************************************************************
    // command field and event detection
    //****************************************************************
    wire logic [3:0] host_cmd   = wdat[3:0];
    wire logic       cmd_wr     = wr_en & hit_cmd;
    wire logic       cmd_bad    = cmd_wr & ~RIRQ_CMD_VALID[host_cmd];  // R14
    wire logic       cmd_finish = EVENTS.cmd_done & (cmd_q != RIRQ_CMD_IDLE)
                                  & ~cmd_wr;                           // R13
    // host writing idle never raises the idle request
    wire logic       idle_evt   = cmd_finish | cmd_bad;                // R15
    wire logic       tx_evt     = EVENTS.tx_last_bit_sent;             // R10
    wire logic       rx_evt     = EVENTS.rx_stream_end
                                  & (~mode_q[RIRQ_RX_IGNORE_BIT]
                                     | EVENTS.fifo_has_bytes);         // R11 R12
    wire logic       high_evt   = EVENTS.fifo_high_live & ~high_prev_q; // R16
    wire logic       low_evt    = EVENTS.fifo_low_live & ~low_prev_q;   // R17
    wire logic       err_evt    = |(EVENTS.error_status & ~err_prev_q); // R18
    wire logic       timer_evt  = EVENTS.timer_zero;                    // R19
    wire logic       aux_evt    = aux_s2_q ^ aux_s3_q;                  // R21
    wire logic       crc_evt    = EVENTS.crc_data_done
                                  & (cmd_q == RIRQ_CMD_CALC_CRC);       // R22

    wire logic [7:0] com_set = {1'b0, tx_evt, rx_evt, idle_evt, high_evt,
                                low_evt, err_evt, timer_evt};
    wire logic [7:0] div_set = {3'b000, aux_evt, 1'b0, crc_evt, 2'b00};

    //****************************************************************
    // next-state of registers
    //****************************************************************
    always_comb begin
        com_ien_d = com_ien_q;
        div_ien_d = div_ien_q;
        mode_d    = mode_q;
        cmd_d     = cmd_q;
        com_irq_d = com_irq_q;
        div_irq_d = div_irq_q;
        if (wr_en & hit_cie) begin
            com_ien_d = wdat;                                          // R4
        end
        if (wr_en & hit_die) begin
            div_ien_d = wdat & RIRQ_DIV_IEN_MASK;                      // R6
        end
        if (wr_en & hit_mod) begin
            mode_d = wdat;
        end
        if (cmd_wr) begin
            cmd_d = cmd_bad ? RIRQ_CMD_IDLE : host_cmd;                // R14
        end else if (cmd_finish) begin
            cmd_d = RIRQ_CMD_IDLE;
        end
        // requests never drop by themselves, only by marker write
        if (wr_en & hit_cir) begin
            com_irq_d = marker_write(com_irq_q, wdat, 8'h7f);          // R8 R9
        end
        if (wr_en & hit_dir) begin
            div_irq_d = marker_write(div_irq_q, wdat, RIRQ_DIV_IRQ_MASK); // R20
        end
        // hardware set wins over a same-cycle clear
        com_irq_d = com_irq_d | com_set;
        div_irq_d = div_irq_d | div_set;
    end

    //****************************************************************
    // registers
    //****************************************************************
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            com_ien_q <= RIRQ_COM_IEN_RST;                             // R7
            div_ien_q <= RIRQ_DIV_IEN_RST;
            com_irq_q <= RIRQ_COM_IRQ_RST;
            div_irq_q <= RIRQ_DIV_IRQ_RST;
            mode_q    <= RIRQ_MODE_RST;
            cmd_q     <= RIRQ_CMD_IDLE;
        end else begin
            com_ien_q <= com_ien_d;
            div_ien_q <= div_ien_d;
            com_irq_q <= com_irq_d;
            div_irq_q <= div_irq_d;
            mode_q    <= mode_d;
            cmd_q     <= cmd_d;
        end
    end

    // edge history of live status and aux synchroniser
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            high_prev_q <= 1'b0;
            low_prev_q  <= 1'b0;
            err_prev_q  <= 8'h00;
            aux_s1_q    <= 1'b0;
            aux_s2_q    <= 1'b0;
            aux_s3_q    <= 1'b0;
        end else begin
            high_prev_q <= EVENTS.fifo_high_live;
            low_prev_q  <= EVENTS.fifo_low_live;
            err_prev_q  <= EVENTS.error_status;
            aux_s1_q    <= AUX_SERIAL_INPUT;
            aux_s2_q    <= aux_s1_q;
            aux_s3_q    <= aux_s2_q;
        end
    end

    //****************************************************************
    // global request and pin drive
    //****************************************************************
    wire logic [6:0] com_pend = com_irq_q[6:0] & com_ien_q[6:0];       // R4
    wire logic [7:0] div_pend = div_irq_q & div_ien_q & RIRQ_DIV_IRQ_MASK; // R6
    wire logic       irq_d    = (|com_pend) | (|div_pend);             // R23
    wire logic       invert   = com_ien_q[RIRQ_INVERT_BIT];
    wire logic       pin_lvl  = irq_d ^ invert;                        // R1 R2
    wire logic       push_pull = div_ien_q[RIRQ_PUSH_PULL_BIT];        // R5

    // open-drain drives only a low level, floats on high
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            irq_q      <= 1'b0;
            irq_out_q  <= 1'b1;
            irq_oe_n_q <= 1'b1;                                        // R3
        end else begin
            irq_q      <= irq_d;                                       // R23
            irq_out_q  <= pin_lvl;                                     // R1 R2
            irq_oe_n_q <= ~(push_pull | ~pin_lvl);                     // R3 R5
        end
    end

    //****************************************************************
    // read path
    //****************************************************************
    wire logic [7:0] status_rd = {3'b000, irq_q, 4'h0};
    wire logic [7:0] rd_byte =
        hit_cmd ? {4'h0, cmd_q} :
        hit_cie ? com_ien_q :
        hit_die ? div_ien_q :
        hit_cir ? {1'b0, com_irq_q[6:0]} :
        hit_dir ? div_irq_q :
        hit_sta ? status_rd :
        hit_mod ? mode_q : 8'h00;

    // read byte captured in the setup cycle, stands through the access phase
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            rd_q <= 8'h00;
        end else if (setup_en) begin
            rd_q <= rd_byte;
        end
    end

    assign PRDATA     = {24'h000000, rd_q};
    assign PREADY     = 1'b1;
    assign PSLVERR    = APB_REQ.psel & APB_REQ.penable & ~hit_any;
    assign COMMAND    = cmd_q;
    assign IRQ_STATUS = irq_q;
    assign IRQ_O      = irq_out_q;
    assign IRQ_OE_N   = irq_oe_n_q;

endmodule

// ---- test/rirq_assertions.sv ----
// checker: pin drive, apb refusal and command field relations
// assumes only the ports of rirq_unit; bound at the foot of this file
module rirq_assertions
    import rirq_pkg::*;
(
    input wire logic                    CLK_SYS,    // clock
    input wire logic                    RESETN,     // sync reset, low
    input wire rirq_pkg::rirq_apb_req_t APB_REQ,    // apb request
    input wire logic [31:0]             PRDATA,     // read data
    input wire logic                    PSLVERR,    // apb error
    input wire rirq_pkg::rirq_events_t  EVENTS,     // source events
    input wire logic [3:0]              COMMAND,    // command field
    input wire logic                    IRQ_STATUS, // global request
    input wire logic                    IRQ_O,      // pin level
    input wire logic                    IRQ_OE_N    // pin drive, low on
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       acc;
    logic       wr;
    logic       cmd_wr;
    logic [7:0] com_q;
    logic [7:0] div_q;
    // decode of the access phase
    assign acc    = APB_REQ.psel & APB_REQ.penable;
    assign wr     = acc & APB_REQ.pwrite;
    assign cmd_wr = wr && APB_REQ.paddr == RIRQ_COMMAND_OFS;
    // mirror of both enable registers
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            com_q <= 8'h80;
            div_q <= 8'h00;
        end else if (wr && APB_REQ.paddr == RIRQ_COM_IEN_OFS) begin
            com_q <= APB_REQ.pwdata[7:0];
        end else if (wr && APB_REQ.paddr == RIRQ_DIV_IEN_OFS) begin
            div_q <= APB_REQ.pwdata[7:0];
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    polarity_a:
        assert property ($stable(com_q[7]) |-> IRQ_O == (IRQ_STATUS ^ com_q[7]))
        else $error("pin level not tied to status and invert");
    push_pull_a:
        assert property ($stable(div_q[7]) && div_q[7] |-> !IRQ_OE_N)
        else $error("push-pull pin not driven");
    open_drain_a:
        assert property ($stable(div_q[7]) && !div_q[7] |-> IRQ_OE_N == IRQ_O)
        else $error("open-drain pin drives high");
    reset_pin_a:
        assert property ($rose(RESETN) |-> IRQ_OE_N && !IRQ_STATUS)
        else $error("pin not floating after reset");
    enables_off_a:
        assert property (com_q[6:0] == 7'h0 && div_q[4] == 1'b0 && div_q[2] == 1'b0
            |=> !IRQ_STATUS) else $error("status high with all enables clear");
    tx_pass_a:
        assert property (com_q[6] && EVENTS.tx_last_bit_sent && !wr |-> ##2 IRQ_STATUS)
        else $error("enabled transmit event not on status");
    bad_cmd_a:
        assert property (cmd_wr && !RIRQ_CMD_VALID[APB_REQ.pwdata[3:0]] |=> COMMAND == 4'h0)
        else $error("unknown command kept");
    cmd_end_a:
        assert property (EVENTS.cmd_done && COMMAND != 4'h0 && !cmd_wr |=> COMMAND == 4'h0)
        else $error("finished command not back to idle");
    unmapped_a:
        assert property (acc && !(APB_REQ.paddr inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
            8'h18, 8'h1c}) |-> PSLVERR && PRDATA == 32'h0) else $error("unmapped not refused");
endmodule

bind rirq_unit rirq_assertions u_chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
    .APB_REQ(APB_REQ), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .EVENTS(EVENTS),
    .COMMAND(COMMAND), .IRQ_STATUS(IRQ_STATUS), .IRQ_O(IRQ_O), .IRQ_OE_N(IRQ_OE_N));

// ---- test/rirq_host_model.sv ----
// host side pin model: resolves the interrupt wire seen by the host
// assumes level and active-low drive enable come straight from the unit
module rirq_host_model (
    input  wire logic drive_level, // level offered by the unit
    input  wire logic drive_off_n, // low while the unit drives
    output logic      pin_level    // wire level at the host
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released wire is pulled up
    assign pin_level = drive_off_n ? 1'b1 : drive_level;
endmodule

// ---- test/rirq_unit_tb_top.sv ----
// testbench: apb register tests, event pulses and pin checks for rirq_unit
// assumes rirq_pkg, the host pin model and the bound checker compiled first
module rirq_unit_tb_top
    import rirq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          clk_sys, resetn, aux_in, pready, slv_err, irq_status, irq_o, irq_oe_n, pin;
    logic          ser;
    rirq_apb_req_t req;
    rirq_events_t  ev;
    logic [31:0]   prdata, rd;
    logic [3:0]    command;
    int            errors, samples_checked;
    logic [15:0]   ev_tab [6] = '{16'h8000, 16'h4000, 16'h1000, 16'h0800, 16'h0008, 16'h0004};
    logic [7:0]    bit_tab [6] = '{8'h40, 8'h20, 8'h08, 8'h04, 8'h02, 8'h01};
    rirq_unit u_dut (.CLK_SYS(clk_sys), .RESETN(resetn), .APB_REQ(req), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(slv_err), .EVENTS(ev), .AUX_SERIAL_INPUT(aux_in),
        .COMMAND(command), .IRQ_STATUS(irq_status), .IRQ_O(irq_o), .IRQ_OE_N(irq_oe_n));
    rirq_host_model u_host (.drive_level(irq_o), .drive_off_n(irq_oe_n), .pin_level(pin));
    // clock generator
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, read data taken at the ready edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        ser = slv_err;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(what, rd, {24'h0, exp});
    endtask
    task automatic fire(input logic [15:0] e);
        ev <= rirq_events_t'(e);
        @(posedge clk_sys);
        ev <= '0;
        @(posedge clk_sys);
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatched %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        give_verdict;
    end
    // main sequence
    initial begin
        req = '0;
        ev = '0;
        aux_in = 1'b0;
        resetn = 1'b0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rdchk("com enable", 8'h08, 8'h80);
        rdchk("div enable", 8'h0c, 8'h00);
        rdchk("com request", 8'h10, 8'h14);
        chk("mapped err", 32'(ser), 32'h0);
        chk("idle pin", 32'(pin), 32'h1);
        $display("test reset done");
        apb(8'h08, 1'b1, 32'h90);
        repeat (2) @(posedge clk_sys);
        chk("inverted pin", 32'(pin), 32'h0);
        apb(8'h08, 1'b1, 32'h10);
        repeat (2) @(posedge clk_sys);
        chk("plain level", 32'(irq_o), 32'h1);
        chk("open drain", 32'(irq_oe_n), 32'h1);
        apb(8'h0c, 1'b1, 32'h80);
        repeat (2) @(posedge clk_sys);
        chk("push pull", 32'(irq_oe_n), 32'h0);
        apb(8'h0c, 1'b1, 32'h0);
        apb(8'h08, 1'b1, 32'h80);
        repeat (2) @(posedge clk_sys);
        chk("blocked", 32'(irq_status), 32'h0);
        $display("test pin done");
        apb(8'h10, 1'b1, 32'h7f);
        rdchk("cleared", 8'h10, 8'h00);
        apb(8'h10, 1'b1, 32'h83);
        rdchk("marker set", 8'h10, 8'h03);
        apb(8'h10, 1'b1, 32'h01);
        rdchk("marker clear", 8'h10, 8'h02);
        apb(8'h10, 1'b1, 32'h02);
        apb(8'h08, 1'b1, 32'hff);
        for (int i = 0; i < 6; i++) begin
            fire(ev_tab[i]);
            rdchk("event bit", 8'h10, bit_tab[i]);
            apb(8'h10, 1'b1, {24'h0, bit_tab[i]});
        end
        apb(8'h08, 1'b1, 32'h80);
        apb(8'h1c, 1'b1, 32'h08);
        fire(16'h4000);
        rdchk("empty rx", 8'h10, 8'h00);
        fire(16'h6000);
        rdchk("rx bytes", 8'h10, 8'h20);
        apb(8'h10, 1'b1, 32'h20);
        apb(8'h1c, 1'b1, 32'h0);
        $display("test events done");
        apb(8'h04, 1'b1, 32'h2);
        rdchk("bad cmd", 8'h04, 8'h00);
        rdchk("bad cmd idle", 8'h10, 8'h10);
        apb(8'h10, 1'b1, 32'h10);
        apb(8'h04, 1'b1, 32'h3);
        apb(8'h04, 1'b1, 32'h0);
        rdchk("host idle", 8'h10, 8'h00);
        apb(8'h04, 1'b1, 32'h3);
        fire(16'h0001);
        rdchk("crc done", 8'h14, 8'h04);
        fire(16'h0002);
        chk("cmd end", 32'(command), 32'h0);
        rdchk("cmd end idle", 8'h10, 8'h10);
        apb(8'h14, 1'b1, 32'h04);
        rdchk("div clear", 8'h14, 8'h00);
        apb(8'h14, 1'b1, 32'h94);
        rdchk("div set", 8'h14, 8'h14);
        apb(8'h14, 1'b1, 32'h14);
        $display("test command done");
        aux_in <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rdchk("aux rise", 8'h14, 8'h10);
        apb(8'h14, 1'b1, 32'h10);
        aux_in <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rdchk("aux fall", 8'h14, 8'h10);
        apb(8'h0c, 1'b1, 32'h10);
        repeat (2) @(posedge clk_sys);
        chk("aux passed", 32'(irq_status), 32'h1);
        apb(8'h0c, 1'b1, 32'h04);
        repeat (2) @(posedge clk_sys);
        chk("aux gated", 32'(irq_status), 32'h0);
        apb(8'h40, 1'b0, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("unmapped err", 32'(ser), 32'h1);
        $display("test aux done");
        give_verdict;
    end
endmodule
